// ---- src/ipr_pkg.sv ----
package ipr_pkg;

   // Source counts: external pins first, then on-chip modules
   localparam int N_EXT = 8;
   localparam int N_MOD = 16;
   localparam int N_SRC = N_EXT + N_MOD;
   localparam int IDX_W = 5;

   // Priority widths
   localparam int EXT_PRIO_W = 4;
   localparam int MOD_PRIO_W = 5;
   localparam int LEVEL_W    = 4;
   localparam int CODE_W     = 12;

   // Module settings below this value block the source
   localparam logic [MOD_PRIO_W-1:0] MOD_PRIO_MIN = 5'h02;
   localparam logic [MOD_PRIO_W-1:0] MOD_PRIO_RST = 5'h00;
   localparam logic [EXT_PRIO_W-1:0] EXT_PRIO_RST = 4'h0;
   localparam logic [LEVEL_W-1:0]    LEVEL_NONE   = 4'h0;

   // Register byte addresses
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_EPRIO  = 8'h04;
   localparam logic [7:0] OFF_MASK   = 8'h08;
   localparam logic [7:0] OFF_MCLR   = 8'h0c;
   localparam logic [7:0] OFF_MPRIO  = 8'h10;
   localparam logic [7:0] OFF_STAT   = 8'h20;
   localparam logic [7:0] OFF_PRES   = 8'h24;
   localparam int         MPRIO_WORDS = 4;
   localparam int         MPRIO_LANE  = 8;

   // Field positions
   localparam int CTRL_NMIMASK_BIT = 0;
   localparam int CTRL_NMIPIN_BIT  = 8;
   localparam int PRES_CODE_LSB    = 8;
   localparam int PRES_NMI_BIT     = 31;

   // Event codes: arbitrary base and spacing, one per source
   localparam logic [CODE_W-1:0] EVT_BASE = 12'h400;
   localparam logic [CODE_W-1:0] EVT_STEP = 12'h020;
   localparam logic [CODE_W-1:0] EVT_NMI  = 12'h1c0;
   localparam logic [CODE_W-1:0] EVT_NONE = 12'h000;

   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ipr_bus_t;

   // What the processor sees
   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic [CODE_W-1:0]  code;
   } ipr_cpu_req_t;

   // Distinct code for each source index
   function automatic logic [CODE_W-1:0] evtCode(input logic [IDX_W-1:0] idx);
      logic [CODE_W-1:0] off;
      off = EVT_STEP * {{(CODE_W-IDX_W){1'b0}}, idx};
      return EVT_BASE + off;
   endfunction : evtCode

endpackage : ipr_pkg

// ---- src/ipr_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for one level
module ipr_sync
(
   input  wire logic clk,    // System clock
   input  wire logic rst,    // Sync reset, high
   input  wire logic async,  // Level from outside
   output logic      synced  // Safe copy
);
   logic meta_q;  // First stage, read only by second

   // Reset to high: an idle pin is high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= 1'b1;
         synced <= 1'b1;
      end
      else
      begin
         meta_q <= async;
         synced <= meta_q;
      end
   end
endmodule : ipr_sync
`default_nettype wire

// ---- src/ipr_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Picks the highest 5-bit priority; ties go to the lower index
module ipr_arbiter
   import ipr_pkg::*;
(
   input  wire logic [N_SRC-1:0][MOD_PRIO_W-1:0] cand,    // Zero means not eligible
   output logic      [IDX_W-1:0]                 winIdx,  // Winning source
   output logic      [MOD_PRIO_W-1:0]            winPrio  // Its priority, zero if none
);
   // Linear scan; strict compare keeps the earlier source on ties
   always_comb
   begin
      winIdx  = '0;
      winPrio = '0;
      for (int i = 0; i < N_SRC; i++)
      begin
         if (cand[i] > winPrio)
         begin
            winIdx  = IDX_W'(i);
            winPrio = cand[i];
         end
      end
   end
endmodule : ipr_arbiter
`default_nettype wire

// ---- src/ipr_resolver.sv ----
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ipr_resolver
   import ipr_pkg::*;
(
   input  wire logic                 clk,          // 100 MHz clock
   input  wire logic                 rst,          // Sync reset, high
   input  wire ipr_bus_t             bus,          // Register request
   output logic         [31:0]       rdData,       // Read data, cycle after
   input  wire logic    [N_EXT-1:0]  extReq,       // External requests
   input  wire logic    [N_MOD-1:0]  modReq,       // Module requests
   input  wire logic                 nmiPin_n,     // NMI pin, active low
   input  wire logic    [LEVEL_W-1:0] cpuMaskLevel, // Processor mask level
   input  wire logic                 cpuAccept,    // Processor took a request
   output ipr_cpu_req_t              cpuReq,       // Level and event code
   output logic                      nmiReq        // NMI pending
);

   // Control and configuration state
   logic                                  nmiMask_q;  // Mask others while NMI low
   logic [N_EXT-1:0][EXT_PRIO_W-1:0]      extPrio_q;  // External priorities
   logic [N_MOD-1:0][MOD_PRIO_W-1:0]      modPrio_q;  // Module priorities
   logic [N_SRC-1:0]                      mask_q;     // One mask bit per source

   // NMI pin path
   logic nmiSync;    // Synchronised pin
   logic nmiPrev_q;  // Last synchronised value
   logic nmiFall;    // Falling edge seen

   // Arbitration signals
   logic [N_SRC-1:0][MOD_PRIO_W-1:0] cand;     // Effective priorities
   logic [IDX_W-1:0]                 winIdx;   // Winner
   logic [MOD_PRIO_W-1:0]            winPrio;  // Winner's priority
   logic [LEVEL_W-1:0]               winLevel; // Reported level
   logic                             nmiBlock; // Others suppressed
   logic                             forward;  // Send to processor
   ipr_cpu_req_t                     cpuReq_d; // Next presented value
   logic                             nmiReq_d; // Next NMI pending

   // Register decode
   logic                  wrCtrl;    // Control write
   logic                  wrEprio;   // External priority write
   logic                  wrMask;    // Mask set write
   logic                  wrMclr;    // Mask clear write
   logic                  mprioHit;  // Address in module priority block
   logic [1:0]            mprioSel;  // Which module priority word
   logic [31:0]           rdData_d;  // Read mux
   logic [MPRIO_WORDS-1:0][31:0] mprioWord; // Packed module priorities
   logic [31:0]           ctrlWord;  // Control readback
   logic [31:0]           presWord;  // Presented request readback
   logic [31:0]           statWord;  // Raw request readback
   logic [N_SRC-1:0]      rawReq;    // All requests, ext first

   // Synchronise the NMI pin before anything looks at it
   ipr_sync uNmiSync
   (
      .clk    (clk),
      .rst    (rst),
      .async  (nmiPin_n),
      .synced (nmiSync)
   );

   // ---- Register write decode ----
   assign wrCtrl   = bus.wr && (bus.addr == OFF_CTRL);
   assign wrEprio  = bus.wr && (bus.addr == OFF_EPRIO);
   assign wrMask   = bus.wr && (bus.addr == OFF_MASK);
   assign wrMclr   = bus.wr && (bus.addr == OFF_MCLR);
   assign mprioHit = (bus.addr[7:4] == OFF_MPRIO[7:4]);
   assign mprioSel = bus.addr[3:2];

   // Control register: only the NMI masking bit is writable
   always_ff @(posedge clk)
   begin
      if (rst)
         nmiMask_q <= 1'b0;
      else if (wrCtrl)
         nmiMask_q <= bus.wdata[CTRL_NMIMASK_BIT];
   end

   // External priorities, four bits each, packed in one word
   always_ff @(posedge clk)
   begin
      if (rst)
         extPrio_q <= {N_EXT{EXT_PRIO_RST}};
      else if (wrEprio)
         extPrio_q <= bus.wdata;
   end

   // Module priorities; reset leaves every module blocked
   always_ff @(posedge clk)
   begin
      if (rst)
         modPrio_q <= {N_MOD{MOD_PRIO_RST}};
      else if (bus.wr && mprioHit)
      begin
         // Four five-bit fields per word, one per byte lane
         for (int m = 0; m < N_MOD; m++)
         begin
            if (mprioSel == 2'(m / MPRIO_WORDS))
               modPrio_q[m] <= bus.wdata[(m % MPRIO_WORDS)*MPRIO_LANE +: MOD_PRIO_W];
         end
      end
   end

   // Mask bits: set register and clear register, both write-one
   always_ff @(posedge clk)
   begin
      if (rst)
         mask_q <= '1;
      else if (wrMask)
         mask_q <= mask_q | bus.wdata[N_SRC-1:0];
      else if (wrMclr)
         mask_q <= mask_q & ~bus.wdata[N_SRC-1:0];
   end

   // ---- Candidate priorities ----
   // External level maps to {level,1} so it fits the 5-bit scale
   // and reports unchanged after the low bit is dropped
   generate
      for (genvar e = 0; e < N_EXT; e++)
      begin : gExt
         assign cand[e] = (extReq[e] && !mask_q[e] && (extPrio_q[e] != EXT_PRIO_RST))
                          ? {extPrio_q[e], 1'b1} : '0;
      end
      for (genvar m = 0; m < N_MOD; m++)
      begin : gMod
         // Settings 0 and 1 never become candidates
         assign cand[N_EXT+m] = (modReq[m] && !mask_q[N_EXT+m] && (modPrio_q[m] >= MOD_PRIO_MIN))
                                ? modPrio_q[m] : '0;
      end
   endgenerate

   // Fixed default order: lower index wins ties, compare on 5 bits
   ipr_arbiter uArb
   (
      .cand    (cand),
      .winIdx  (winIdx),
      .winPrio (winPrio)
   );

   // ---- Forward decision ----
   // Losers are not stored: they stay visible as long as their
   // source holds the request, so nothing is lost when one wins
   assign winLevel = winPrio[MOD_PRIO_W-1:1];
   assign nmiBlock = nmiMask_q && !nmiSync;
   assign forward  = (winLevel > cpuMaskLevel) && !nmiBlock;

   // Level zero when nothing is forwarded; no code then unless NMI is pending
   assign cpuReq_d.level = forward ? winLevel : LEVEL_NONE;
   // Next pending value, so the code flips in the same edge as nmiReq
   assign cpuReq_d.code  = nmiReq_q_code(nmiReq_d, forward, winIdx);

   // Code selection: NMI first, then the winner's own code
   function automatic logic [CODE_W-1:0] nmiReq_q_code(input logic nmi,
                                                       input logic fwd,
                                                       input logic [IDX_W-1:0] idx);
      logic [CODE_W-1:0] c;
      c = EVT_NONE;
      if (nmi)
         c = EVT_NMI;
      else if (fwd)
         c = evtCode(idx);
      return c;
   endfunction : nmiReq_q_code

   // Level and code share one register so they never disagree
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cpuReq.level <= LEVEL_NONE;
         cpuReq.code  <= EVT_NONE;
      end
      else
         cpuReq <= cpuReq_d;
   end

   // ---- NMI pending ----
   // Only the synchronised copy feeds the edge detector
   assign nmiFall = nmiPrev_q && !nmiSync;

   // A new edge wins over an acceptance in the same cycle
   assign nmiReq_d = nmiFall ? 1'b1 : (cpuAccept ? 1'b0 : nmiReq);

   // Edge history and pending flag
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nmiPrev_q <= 1'b1;
         nmiReq    <= 1'b0;
      end
      else
      begin
         nmiPrev_q <= nmiSync;
         nmiReq    <= nmiReq_d;
      end
   end

   // ---- Read side ----
   assign rawReq = {modReq, extReq};

   // Pack module priorities back into their words
   generate
      for (genvar w = 0; w < MPRIO_WORDS; w++)
      begin : gWord
         for (genvar l = 0; l < MPRIO_WORDS; l++)
         begin : gLane
            assign mprioWord[w][l*MPRIO_LANE +: MPRIO_LANE] =
               {{(MPRIO_LANE-MOD_PRIO_W){1'b0}}, modPrio_q[w*MPRIO_WORDS+l]};
         end
      end
   endgenerate

   // Control word shows the mask bit and the pin level
   assign ctrlWord = (32'(nmiMask_q) << CTRL_NMIMASK_BIT)
                   | (32'(nmiSync) << CTRL_NMIPIN_BIT);

   // What the processor is being shown right now
   assign presWord = (32'(nmiReq) << PRES_NMI_BIT)
                   | (32'(cpuReq.code) << PRES_CODE_LSB)
                   | 32'(cpuReq.level);

   // Requests still waiting, masked or not
   assign statWord = 32'(rawReq);

   // Read mux; unmapped addresses read zero
   assign rdData_d = !bus.rd                ? 32'h0000_0000 :
                     (bus.addr == OFF_CTRL)  ? ctrlWord :
                     (bus.addr == OFF_EPRIO) ? 32'(extPrio_q) :
                     (bus.addr == OFF_MASK)  ? 32'(mask_q) :
                     mprioHit                ? mprioWord[mprioSel] :
                     (bus.addr == OFF_STAT)  ? statWord :
                     (bus.addr == OFF_PRES)  ? presWord :
                                               32'h0000_0000;

   // Read data stands for one cycle only
   always_ff @(posedge clk)
   begin
      if (rst)
         rdData <= 32'h0000_0000;
      else
         rdData <= rdData_d;
   end

endmodule : ipr_resolver
`default_nettype wire

// ---- tb/ipr_resolver_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the priority resolver
module ipr_resolver_properties
   import ipr_pkg::*;
(
   input wire logic               clk,          // Clock
   input wire logic               rst,          // Sync reset
   input wire ipr_bus_t           bus,          // Register request
   input wire logic [31:0]        rdData,       // Read data
   input wire logic [N_EXT-1:0]   extReq,       // External requests
   input wire logic [N_MOD-1:0]   modReq,       // Module requests
   input wire logic               nmiPin_n,     // NMI pin
   input wire logic [LEVEL_W-1:0] cpuMaskLevel, // Processor mask
   input wire logic               cpuAccept,    // Acceptance pulse
   input wire ipr_cpu_req_t       cpuReq,       // Presented request
   input wire logic               nmiReq        // NMI pending
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic nmiMask_q;  // Shadow of the NMI mask bit
   logic maskNew_q;  // Masks untouched since reset
   // Track control and mask writes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nmiMask_q <= 1'b0;
         maskNew_q <= 1'b1;
      end
      else if (bus.wr)
      begin
         if (bus.addr == OFF_CTRL)
            nmiMask_q <= bus.wdata[CTRL_NMIMASK_BIT];
         if (bus.addr == OFF_MASK || bus.addr == OFF_MCLR)
            maskNew_q <= 1'b0;
      end
   end
   reset_clears_a: assert property (disable iff (1'b0) rst |=> cpuReq == '0 && !nmiReq)
      else $error("outputs not cleared by reset");
   above_mask_a: assert property (cpuReq.level != LEVEL_NONE |-> cpuReq.level > $past(cpuMaskLevel))
      else $error("level presented at or below mask");
   nmi_code_a: assert property (nmiReq |-> cpuReq.code == EVT_NMI)
      else $error("NMI pending without its code");
   idle_code_a: assert property (!nmiReq && cpuReq.level == LEVEL_NONE |-> cpuReq.code == EVT_NONE)
      else $error("code shown with no request");
   no_request_a: assert property (extReq == '0 && modReq == '0 |=> cpuReq.level == LEVEL_NONE)
      else $error("level with no source raised");
   nmi_masks_a: assert property ((nmiMask_q && !nmiPin_n) [*4] |=> cpuReq.level == LEVEL_NONE)
      else $error("request passed while NMI low");
   nmi_raise_a: assert property ($fell(nmiPin_n) |-> ##[1:4] nmiReq)
      else $error("NMI fall not reported");
   nmi_clear_a: assert property ((!nmiPin_n) [*6] ##0 (nmiReq && cpuAccept) |=> !nmiReq)
      else $error("NMI pending not cleared");
   mask_reset_a: assert property (maskNew_q && bus.rd && bus.addr == OFF_MASK |=> rdData == 32'h00ffffff)
      else $error("masks not all set after reset");
endmodule : ipr_resolver_properties
bind ipr_resolver ipr_resolver_properties ipr_resolver_properties_i (.clk(clk), .rst(rst), .bus(bus),
   .rdData(rdData), .extReq(extReq), .modReq(modReq), .nmiPin_n(nmiPin_n), .cpuMaskLevel(cpuMaskLevel),
   .cpuAccept(cpuAccept), .cpuReq(cpuReq), .nmiReq(nmiReq));
`default_nettype wire

// ---- tb/ipr_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Processor side: accepts requests at instruction boundaries
module ipr_cpu_model
   import ipr_pkg::*;
(
   input  wire logic               clk,          // Clock
   input  wire logic               rst,          // Sync reset
   input  wire ipr_cpu_req_t       cpuReq,       // Presented request
   input  wire logic               nmiReq,       // NMI pending
   input  wire logic               acceptEn,     // Accept allowed
   input  wire logic               slow,         // Boundary every 4 cycles
   input  wire logic               autoMask,     // Auto mask update
   input  wire logic               setMask,      // Mask follows maskIn
   input  wire logic [LEVEL_W-1:0] maskIn,       // Forced mask
   output logic      [LEVEL_W-1:0] cpuMaskLevel, // Mask level
   output logic                    cpuAccept,    // Acceptance pulse
   output logic      [CODE_W-1:0]  codeSeen      // Event code taken
);
   logic [1:0] instr_q;   // Instruction length counter
   logic       boundary;  // Between instructions
   logic       take;      // Accept now
   assign boundary = !slow || instr_q == 2'h0;
   assign take = acceptEn && boundary && !cpuAccept && (nmiReq || cpuReq.level != LEVEL_NONE);
   // Acceptance, code latch and mask update
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         instr_q <= 2'h0;
         cpuAccept <= 1'b0;
         codeSeen <= EVT_NONE;
         cpuMaskLevel <= 4'h0;
      end
      else
      begin
         instr_q <= instr_q + 2'h1;
         // Acceptance stands for state save and entry to the one shared handler
         cpuAccept <= take;
         if (take)
            codeSeen <= cpuReq.code;
         if (setMask)
            cpuMaskLevel <= maskIn;
         else if (take && autoMask && !nmiReq)
            cpuMaskLevel <= cpuReq.level;
      end
   end
endmodule : ipr_cpu_model
`default_nettype wire

// ---- tb/ipr_resolver_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: reads queue notes, monitor compares
module ipr_resolver_bench
   import ipr_pkg::*;
;
   logic               clk, rst, nmiPin_n, cpuAccept, nmiReq, rdSeen;
   logic               acceptEn, autoMask, slow, setMask;
   ipr_bus_t           bus;          // Register request
   logic [31:0]        rdData;       // Read data
   logic [N_EXT-1:0]   extReq;       // External requests
   logic [N_MOD-1:0]   modReq;       // Module requests
   logic [LEVEL_W-1:0] cpuMaskLevel, maskIn;
   ipr_cpu_req_t       cpuReq;       // Presented request
   logic [CODE_W-1:0]  codeSeen;     // Code the processor took
   logic [31:0]        expQ[$];      // Expected read data
   logic [3:0]         eprio[N_EXT]; // External priorities
   logic [4:0]         mprio[N_MOD]; // Module priorities
   logic [9:0]         pairs[5] = '{{5'h1a, 5'h1b}, {5'h1b, 5'h1a}, {5'h1b, 5'h1b}, {5'h01, 5'h00}, {5'h02, 5'h01}};
   int                 fails, num_checks;
   ipr_resolver ipr_resolver_i (.clk(clk), .rst(rst), .bus(bus), .rdData(rdData), .extReq(extReq),
      .modReq(modReq), .nmiPin_n(nmiPin_n), .cpuMaskLevel(cpuMaskLevel), .cpuAccept(cpuAccept),
      .cpuReq(cpuReq), .nmiReq(nmiReq));
   ipr_cpu_model ipr_cpu_model_i (.clk(clk), .rst(rst), .cpuReq(cpuReq), .nmiReq(nmiReq),
      .acceptEn(acceptEn), .slow(slow), .autoMask(autoMask), .setMask(setMask), .maskIn(maskIn),
      .cpuMaskLevel(cpuMaskLevel), .cpuAccept(cpuAccept), .codeSeen(codeSeen));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   // One-cycle read strobe; the note goes to the queue
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      @(posedge clk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
   endtask : rd
   // Presented word from priorities and requests
   function automatic logic [31:0] expPres(input logic [3:0] mask);
      logic [4:0]  bp;
      logic [11:0] code;
      bp = 5'h00;
      code = EVT_NONE;
      for (int i = 0; i < N_EXT; i++)
         if (extReq[i] && eprio[i] != 4'h0 && {eprio[i], 1'b1} > bp)
         begin
            bp = {eprio[i], 1'b1};
            code = EVT_BASE + EVT_STEP * 12'(i);
         end
      // Strict compare keeps ties with the lower index
      for (int m = 0; m < N_MOD; m++)
         if (modReq[m] && mprio[m] >= MOD_PRIO_MIN && mprio[m] > bp)
         begin
            bp = mprio[m];
            code = EVT_BASE + EVT_STEP * 12'(m + N_EXT);
         end
      if (bp[4:1] <= mask)
         return 32'h0;
      return {1'b0, 11'h0, code, 4'h0, bp[4:1]};
   endfunction : expPres
   // Program priorities while masked, then compare presented word
   task automatic apply(input logic [3:0] mask);
      logic [31:0] w;
      wr(OFF_MASK, 32'h00ffffff);
      w = '0;
      for (int i = 0; i < N_EXT; i++)
         w[4*i +: 4] = eprio[i];
      wr(OFF_EPRIO, w);
      for (int k = 0; k < MPRIO_WORDS; k++)
      begin
         w = '0;
         for (int j = 0; j < 4; j++)
            w[MPRIO_LANE*j +: 5] = mprio[4*k+j];
         wr(OFF_MPRIO + 8'(4*k), w);
         rd(OFF_MPRIO + 8'(4*k), w);
      end
      wr(OFF_MCLR, 32'h00ffffff);
      maskIn <= mask;
      repeat (4) @(posedge clk);
      rd(OFF_PRES, expPres(mask));
   endtask : apply
   // Oldest note meets the read data
   always @(posedge clk)
   begin
      if (rdSeen)
      begin
         if (expQ.size() == 0)
            fails++;
         else
            check(rdData, expQ.pop_front());
      end
      rdSeen <= bus.rd && !rst;
   end
   initial
   begin
      rst = 1'b1;
      rdSeen = 1'b0;
      bus = '0;
      extReq = '0;
      modReq = '0;
      nmiPin_n = 1'b1;
      {acceptEn, autoMask, slow} = 3'h0;
      setMask = 1'b1;
      maskIn = 4'h0;
      fails = 0;
      num_checks = 0;
      void'($urandom(67552));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_MASK, 32'h00ffffff);
      rd(OFF_MPRIO, 32'h0);
      rd(8'h30, 32'h0);
      rd(OFF_CTRL, 32'h100);
      $display("reset test done");
      foreach (eprio[i]) eprio[i] = 4'h0;
      foreach (mprio[i]) mprio[i] = 5'h00;
      modReq <= 16'hffff;
      apply(4'h0);
      for (int t = 0; t < 5; t++)
      begin
         {mprio[0], mprio[1]} = pairs[t];
         apply(4'h0);
      end
      mprio[1] = 5'h1b;
      apply(4'hd);
      apply(4'hc);
      $display("ranking test done");
      // Prompt with auto mask, then slow without it
      for (int a = 0; a < 2; a++)
      begin
         setMask <= 1'b1;
         maskIn <= 4'h0;
         repeat (4) @(posedge clk);
         autoMask <= a == 0;
         slow <= a == 1;
         setMask <= 1'b0;
         acceptEn <= 1'b1;
         repeat (12) @(posedge clk);
         acceptEn <= 1'b0;
         repeat (4) @(posedge clk);
         rd(OFF_PRES, a == 0 ? 32'h0 : expPres(4'h0));
         check({20'h0, codeSeen}, {20'h0, EVT_BASE + EVT_STEP * 12'(9)});
      end
      setMask <= 1'b1;
      $display("accept test done");
      wr(OFF_CTRL, 32'h1);
      nmiPin_n <= 1'b0;
      for (int n = 0; n < 10 && nmiReq !== 1'b1; n++)
         @(posedge clk);
      if (nmiReq !== 1'b1)
      begin
         fails++;
         wrap_up;
      end
      repeat (4) @(posedge clk);
      rd(OFF_PRES, {1'b1, 11'h0, EVT_NMI, 8'h0});
      rd(OFF_CTRL, 32'h1);
      acceptEn <= 1'b1;
      repeat (8) @(posedge clk);
      acceptEn <= 1'b0;
      rd(OFF_PRES, 32'h0);
      nmiPin_n <= 1'b1;
      wr(OFF_CTRL, 32'h0);
      $display("nmi test done");
      for (int r = 0; r < 16; r++)
      begin
         foreach (eprio[i]) eprio[i] = 4'($urandom);
         foreach (mprio[i]) mprio[i] = 5'($urandom);
         extReq <= 8'($urandom);
         modReq <= 16'($urandom);
         apply(4'($urandom_range(7)));
      end
      repeat (2) @(posedge clk);
      $display("random test done");
      wrap_up;
   end
endmodule : ipr_resolver_bench
`default_nettype wire
